// *** hw/route_sense_cfg.svh ***
`ifndef ROUTE_SENSE_CFG_SVH
`define ROUTE_SENSE_CFG_SVH

`define SLAVE_ADDR        7'h20
`define NUM_INPUTS        6
`define ROUTE_ADDR        8'h00
`define SENSE_ONE_ADDR    8'h5D
`define SENSE_TWO_ADDR    8'h5E
`define SENSE_STATUS_ADDR 8'h5F
`define ROUTE_MSB         4
`define OFF_BIT           6
`define LEVEL_MSB         4
`define LEVEL_LSB         2
`define ROUTE_RESET       5'h00
`define OFF_RESET         1'b1
`define LEVEL_RESET       3'h3
`define FIRST_RESERVED    5'h12

`endif

// *** hw/route_sense_pkg.sv ***
package route_sense_pkg;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_SUB       = 9'h008,
    ST_SUB_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RDATA_ACK = 9'h100
  } port_state_t;

  typedef enum logic [2:0] {
    FMT_NONE = 3'h0,
    FMT_CVBS = 3'h1,
    FMT_YC   = 3'h2,
    FMT_COMP = 3'h3,
    FMT_DIFF = 3'h4
  } video_fmt_t;

  typedef struct packed {
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_d;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_d;
    logic [1:0]  trip_s1;
    logic [1:0]  trip_s2;
    port_state_t st;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  subaddr;
    logic        sda_oe;
    logic [4:0]  route;
    logic [1:0]  comp_off;
    logic [2:0]  level_one;
    logic [2:0]  level_two;
    logic [1:0]  status;
    logic        irq_n;
    video_fmt_t  fmt;
    logic [3:0]  ch_a;
    logic [3:0]  ch_b;
    logic [3:0]  ch_c;
    logic [7:0]  ain_pd;
  } core_t;

endpackage : route_sense_pkg

// *** hw/route_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "route_sense_cfg.svh"

module route_decoder
  import route_sense_pkg::*;
#(
  parameter int NUM_INPUTS = `NUM_INPUTS
) (
  input  wire logic [4:0] route_code,
  output video_fmt_t      fmt,
  output logic [3:0]      ch_a,
  output logic [3:0]      ch_b,
  output logic [3:0]      ch_c,
  output logic [7:0]      ch_used
);

  logic [3:0] k;
  logic       ok;

  // Each code maps to one fixed connection or to none; the last CVBS, Y/C and differential codes always land on the top inputs.
  always_comb
  begin
    k    = 4'h0;
    ok   = 1'b0;
    fmt  = FMT_NONE;
    ch_a = 4'h0;
    ch_b = 4'h0;
    ch_c = 4'h0;
    if (route_code <= 5'h07)
    begin
      fmt = FMT_CVBS;
      if (route_code >= 5'h06)
      begin
        ch_a = 4'(NUM_INPUTS) - 4'(5'h07 - route_code);
        ok   = 1'b1;
      end
      else
      begin
        ch_a = 4'(route_code) + 4'h1;
        ok   = (int'(route_code) + 3) <= NUM_INPUTS;
      end
    end
    else if (route_code <= 5'h0B || (route_code >= 5'h0E && route_code <= 5'h11))
    begin
      fmt = (route_code <= 5'h0B) ? FMT_YC : FMT_DIFF;
      k   = (route_code <= 5'h0B) ? 4'(route_code - 5'h08) : 4'(route_code - 5'h0E);
      if (k == 4'h3)
      begin
        ch_a = 4'(NUM_INPUTS - 1);
        ch_b = 4'(NUM_INPUTS);
        ok   = 1'b1;
      end
      else
      begin
        ch_a = 4'((k << 1) + 4'h1);
        ch_b = 4'((k << 1) + 4'h2);
        ok   = (2 * int'(k) + 4) <= NUM_INPUTS;
      end
    end
    else if (route_code <= 5'h0D)
    begin
      fmt  = FMT_COMP;
      k    = 4'(route_code - 5'h0C);
      ch_a = 4'(k * 4'h3 + 4'h1);
      ch_b = 4'(k * 4'h3 + 4'h2);
      ch_c = 4'(k * 4'h3 + 4'h3);
      ok   = (3 * int'(k) + 5) <= NUM_INPUTS;
    end
    if (!ok)
    begin
      fmt  = FMT_NONE;
      ch_a = 4'h0;
      ch_b = 4'h0;
      ch_c = 4'h0;
    end
  end

  for (genvar i = 0; i < 8; i++)
  begin : g_used
    assign ch_used[i] = (ch_a == 4'(i + 1)) || (ch_b == 4'(i + 1)) || (ch_c == 4'(i + 1));
  end

endmodule : route_decoder

`default_nettype wire

// *** hw/fault_flag.sv ***
`timescale 1ns/1ps
`default_nettype none

module fault_flag (
  input  wire logic trip,
  input  wire logic comparator_off,
  input  wire logic status,
  input  wire logic clear,
  output logic      status_next
);

  // A trip in the clearing cycle survives, so no event is lost to a race with software.
  assign status_next = (trip & ~comparator_off) | (status & ~clear);

endmodule : fault_flag

`default_nettype wire

// *** hw/video_input_route_and_fault_sense.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "route_sense_cfg.svh"

module video_input_route_and_fault_sense
  import route_sense_pkg::*;
#(
  parameter int NUM_INPUTS = `NUM_INPUTS
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       fault_sense_pin_one_trip,
  input  wire logic       fault_sense_pin_two_trip,
  output logic            sense_one_comparator_off,
  output logic            sense_two_comparator_off,
  output logic [2:0]      sense_one_threshold,
  output logic [2:0]      sense_two_threshold,
  output logic            interrupt_request_out_n,
  output video_fmt_t      sd_processing_core_format,
  output logic [3:0]      route_ch_a,
  output logic [3:0]      route_ch_b,
  output logic [3:0]      route_ch_c,
  output logic [7:0]      analog_input_channel_pd
);

  core_t       cur;
  core_t       nxt;
  video_fmt_t  dec_fmt;
  logic [3:0]  dec_a;
  logic [3:0]  dec_b;
  logic [3:0]  dec_c;
  logic [7:0]  dec_used;
  logic [1:0]  status_next;
  logic [1:0]  clear;
  logic [1:0]  trips;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;

  route_decoder #(
    .NUM_INPUTS (NUM_INPUTS)
  ) u_decoder (
    .route_code (cur.route),
    .fmt        (dec_fmt),
    .ch_a       (dec_a),
    .ch_b       (dec_b),
    .ch_c       (dec_c),
    .ch_used    (dec_used)
  );

  assign trips = cur.trip_s2;
  assign clear = (wr_stb && wr_addr == `SENSE_STATUS_ADDR) ? wr_data[1:0] : 2'b00;

  for (genvar i = 0; i < 2; i++)
  begin : g_sense
    fault_flag u_flag (
      .trip           (trips[i]),
      .comparator_off (cur.comp_off[i]),
      .status         (cur.status[i]),
      .clear          (clear[i]),
      .status_next    (status_next[i])
    );
  end

  always_comb
  begin
    unique case (cur.subaddr)
      `ROUTE_ADDR:        rd_data = {3'h0, cur.route};
      `SENSE_ONE_ADDR:    rd_data = {1'b0, cur.comp_off[0], 1'b0, cur.level_one, 2'h0};
      `SENSE_TWO_ADDR:    rd_data = {1'b0, cur.comp_off[1], 1'b0, cur.level_two, 2'h0};
      `SENSE_STATUS_ADDR: rd_data = {6'h00, cur.status};
      default:            rd_data = 8'h00;
    endcase
  end

  always_comb
  begin
    nxt        = cur;
    nxt.scl_s1 = scl_in;
    nxt.scl_s2 = cur.scl_s1;
    nxt.scl_d  = cur.scl_s2;
    nxt.sda_s1 = sda_in;
    nxt.sda_s2 = cur.sda_s1;
    nxt.sda_d  = cur.sda_s2;
    // The comparators are analog and asynchronous, so they are synchronised first.
    nxt.trip_s1 = {fault_sense_pin_two_trip, fault_sense_pin_one_trip};
    nxt.trip_s2 = cur.trip_s1;
    scl_rise   = cur.scl_s2 & ~cur.scl_d;
    scl_fall   = ~cur.scl_s2 & cur.scl_d;
    start_seen = cur.scl_s2 & cur.scl_d & cur.sda_d & ~cur.sda_s2;
    stop_seen  = cur.scl_s2 & cur.scl_d & ~cur.sda_d & cur.sda_s2;
    wr_stb     = 1'b0;
    wr_addr    = cur.subaddr;
    wr_data    = cur.shreg;

    if (start_seen)
    begin
      nxt.st     = ST_ADDR;
      nxt.bitcnt = 4'h0;
      nxt.sda_oe = 1'b0;
    end
    else if (stop_seen)
    begin
      nxt.st     = ST_IDLE;
      nxt.sda_oe = 1'b0;
    end
    else
    begin
      case (cur.st)
        ST_ADDR, ST_SUB, ST_WDATA:
        begin
          if (scl_rise)
          begin
            nxt.shreg  = {cur.shreg[6:0], cur.sda_s2};
            nxt.bitcnt = cur.bitcnt + 4'h1;
          end
          else if (scl_fall && cur.bitcnt == 4'h8)
          begin
            nxt.sda_oe = 1'b1;
            if (cur.st == ST_ADDR)
            begin
              nxt.st = (cur.shreg[7:1] == `SLAVE_ADDR) ? ST_ADDR_ACK : ST_IDLE;
              nxt.sda_oe = (cur.shreg[7:1] == `SLAVE_ADDR);
            end
            else if (cur.st == ST_SUB)
            begin
              nxt.subaddr = cur.shreg;
              nxt.st      = ST_SUB_ACK;
            end
            else
            begin
              wr_stb      = 1'b1;
              nxt.subaddr = cur.subaddr + 8'h01;
              nxt.st      = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            nxt.bitcnt = 4'h0;
            if (cur.shreg[0])
            begin
              nxt.shreg  = rd_data;
              nxt.sda_oe = ~rd_data[7];
              nxt.st     = ST_RDATA;
            end
            else
            begin
              nxt.sda_oe = 1'b0;
              nxt.st     = ST_SUB;
            end
          end
        end
        ST_SUB_ACK, ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            nxt.sda_oe = 1'b0;
            nxt.bitcnt = 4'h0;
            nxt.st     = ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (scl_rise)
          begin
            nxt.bitcnt = cur.bitcnt + 4'h1;
          end
          else if (scl_fall && cur.bitcnt == 4'h8)
          begin
            nxt.sda_oe  = 1'b0;
            nxt.subaddr = cur.subaddr + 8'h01;
            nxt.st      = ST_RDATA_ACK;
          end
          else if (scl_fall)
          begin
            nxt.sda_oe = ~cur.shreg[6];
            nxt.shreg  = {cur.shreg[6:0], 1'b0};
          end
        end
        ST_RDATA_ACK:
        begin
          if (scl_rise)
          begin
            nxt.st = cur.sda_s2 ? ST_IDLE : ST_RDATA_ACK;
            nxt.bitcnt = 4'h9;
          end
          else if (scl_fall && cur.bitcnt == 4'h9)
          begin
            nxt.bitcnt = 4'h0;
            nxt.shreg  = rd_data;
            nxt.sda_oe = ~rd_data[7];
            nxt.st     = ST_RDATA;
          end
        end
        default:
        begin
          nxt.st     = ST_IDLE;
          nxt.sda_oe = 1'b0;
        end
      endcase
    end

    if (wr_stb)
    begin
      case (wr_addr)
        `ROUTE_ADDR: nxt.route = wr_data[`ROUTE_MSB:0];
        `SENSE_ONE_ADDR:
        begin
          nxt.comp_off[0] = wr_data[`OFF_BIT];
          nxt.level_one   = wr_data[`LEVEL_MSB:`LEVEL_LSB];
        end
        `SENSE_TWO_ADDR:
        begin
          nxt.comp_off[1] = wr_data[`OFF_BIT];
          nxt.level_two   = wr_data[`LEVEL_MSB:`LEVEL_LSB];
        end
        default: nxt.route = cur.route;
      endcase
    end

    nxt.status = status_next;
    // The request follows the flags of powered comparators only, so a disabled pin cannot hold it low.
    nxt.irq_n  = ~|(status_next & ~nxt.comp_off);
    nxt.fmt    = dec_fmt;
    nxt.ch_a   = dec_a;
    nxt.ch_b   = dec_b;
    nxt.ch_c   = dec_c;
    nxt.ain_pd = ~dec_used;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur           <= '0;
      cur.scl_s1    <= 1'b1;
      cur.scl_s2    <= 1'b1;
      cur.scl_d     <= 1'b1;
      cur.sda_s1    <= 1'b1;
      cur.sda_s2    <= 1'b1;
      cur.sda_d     <= 1'b1;
      cur.st        <= ST_IDLE;
      cur.route     <= `ROUTE_RESET;
      cur.comp_off  <= {`OFF_RESET, `OFF_RESET};
      cur.level_one <= `LEVEL_RESET;
      cur.level_two <= `LEVEL_RESET;
      cur.irq_n     <= 1'b1;
      cur.fmt       <= FMT_NONE;
      cur.ain_pd    <= 8'hFF;
    end
    else
    begin
      cur <= nxt;
    end
  end

  // The pin is open drain: only a low is ever driven.
  assign sda_out                   = 1'b0;
  assign sda_oe                    = cur.sda_oe;
  assign sense_one_comparator_off  = cur.comp_off[0];
  assign sense_two_comparator_off  = cur.comp_off[1];
  assign sense_one_threshold       = cur.level_one;
  assign sense_two_threshold       = cur.level_two;
  assign interrupt_request_out_n   = cur.irq_n;
  assign sd_processing_core_format = cur.fmt;
  assign route_ch_a                = cur.ch_a;
  assign route_ch_b                = cur.ch_b;
  assign route_ch_c                = cur.ch_c;
  assign analog_input_channel_pd   = cur.ain_pd;

  route_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_stb && wr_addr == `ROUTE_ADDR |=> cur.route == $past(wr_data[4:0]))
    else $error("route select did not take the written value");

  yc_decode_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cur.route == 5'h08 && $stable(cur.route) |=> cur.fmt == FMT_YC && cur.ch_a == 4'h1 && cur.ch_b == 4'h2)
    else $error("code 01000 did not route luma/chroma to inputs one and two");

  cvbs_powerdown_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cur.fmt == FMT_CVBS |-> $countones(cur.ain_pd) == 7)
    else $error("composite scheme left an unused channel powered");

  reserved_code_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cur.route >= `FIRST_RESERVED |=> cur.ain_pd == 8'hFF && cur.fmt == FMT_NONE)
    else $error("reserved route code connected an input");

  trip_sets_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cur.trip_s2[0] && !cur.comp_off[0] |=> cur.status[0])
    else $error("enabled trip did not set its status flag");

  status_sticky_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cur.status[1] && !clear[1] |=> cur.status[1])
    else $error("status flag dropped without a clear");

  disabled_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cur.comp_off == 2'b11 && cur.status == 2'b00 |=> cur.status == 2'b00)
    else $error("status set while comparators are off");

  irq_follows_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    interrupt_request_out_n == !(|(cur.status & ~cur.comp_off)))
    else $error("interrupt pin disagrees with enabled status flags");

  level_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_stb && wr_addr == `SENSE_TWO_ADDR |=> sense_two_threshold == $past(wr_data[4:2]))
    else $error("threshold field did not take the written value");

endmodule : video_input_route_and_fault_sense

`default_nettype wire

// *** dv/two_wire_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "route_sense_cfg.svh"

module two_wire_host (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_pull
);
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Eight clocks per step, so at least eight per phase, keep both clock phases well above the four-clock minimum.
  task automatic half();
    repeat (8) @(negedge sys_clk);
  endtask : half

  // Data moves only in the middle of the low phase, so no edge can be taken for a start or stop.
  task automatic bit_io(input logic v, output logic r);
    sda_pull = ~v;
    half();
    scl = 1'b1;
    half();
    r = sda_line;
    scl = 1'b0;
    half();
  endtask : bit_io

  task automatic start();
    sda_pull = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask : start

  task automatic stop();
    sda_pull = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b0;
    half();
  endtask : stop

  task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r[i]);
    bit_io(last, a);
    ack = ~a;
  endtask : xfer

  task automatic write_reg(input logic [7:0] sub, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    xfer({`SLAVE_ADDR, 1'b0}, 1'b1, r, a0);
    xfer(sub, 1'b1, r, a1);
    xfer(d, 1'b1, r, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] sub, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start();
    xfer({`SLAVE_ADDR, 1'b0}, 1'b1, r, a0);
    xfer(sub, 1'b1, r, a1);
    start();
    xfer({`SLAVE_ADDR, 1'b1}, 1'b1, r, a2);
    xfer(8'hFF, 1'b1, d, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask : read_reg
endmodule : two_wire_host
`default_nettype wire

// *** dv/video_input_route_and_fault_sense_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module video_input_route_and_fault_sense_tb
  import route_sense_pkg::*;
;
  typedef struct packed {
    logic [4:0] code;
    video_fmt_t fmt;
    logic [3:0] a;
    logic [3:0] b;
    logic [3:0] c;
  } row_t;

  localparam row_t ROWS [17] = '{
    '{5'h00, FMT_CVBS, 4'h1, 4'h0, 4'h0}, '{5'h04, FMT_NONE, 4'h0, 4'h0, 4'h0},
    '{5'h03, FMT_CVBS, 4'h4, 4'h0, 4'h0}, '{5'h06, FMT_CVBS, 4'h5, 4'h0, 4'h0},
    '{5'h09, FMT_YC, 4'h3, 4'h4, 4'h0}, '{5'h0A, FMT_NONE, 4'h0, 4'h0, 4'h0},
    '{5'h0F, FMT_DIFF, 4'h3, 4'h4, 4'h0}, '{5'h10, FMT_NONE, 4'h0, 4'h0, 4'h0},
    '{5'h07, FMT_CVBS, 4'h6, 4'h0, 4'h0}, '{5'h08, FMT_YC, 4'h1, 4'h2, 4'h0},
    '{5'h0B, FMT_YC, 4'h5, 4'h6, 4'h0}, '{5'h0C, FMT_COMP, 4'h1, 4'h2, 4'h3},
    '{5'h0D, FMT_NONE, 4'h0, 4'h0, 4'h0}, '{5'h0E, FMT_DIFF, 4'h1, 4'h2, 4'h0},
    '{5'h11, FMT_DIFF, 4'h5, 4'h6, 4'h0}, '{5'h12, FMT_NONE, 4'h0, 4'h0, 4'h0},
    '{5'h1F, FMT_NONE, 4'h0, 4'h0, 4'h0}};

  logic       sys_clk;
  logic       nrst;
  logic       scl;
  logic       sda_pull;
  logic       sda_line;
  logic       sda_out;
  logic       sda_oe;
  logic       trip_one;
  logic       trip_two;
  logic       off_one;
  logic       off_two;
  logic       irq_n;
  logic [2:0] thr_one;
  logic [2:0] thr_two;
  video_fmt_t fmt;
  logic [3:0] ch_a;
  logic [3:0] ch_b;
  logic [3:0] ch_c;
  logic [7:0] pd;
  logic [7:0] pd_exp;
  logic [7:0] rd;
  logic       ok;
  int         err_count;
  int         tests_run;

  // The data line is pulled up, so it is low only while some party pulls it.
  assign sda_line = ~((sda_oe & ~sda_out) | sda_pull);

  video_input_route_and_fault_sense #(.NUM_INPUTS(6)) dut (
    .sys_clk                   (sys_clk),
    .nrst                      (nrst),
    .scl_in                    (scl),
    .sda_in                    (sda_line),
    .sda_out                   (sda_out),
    .sda_oe                    (sda_oe),
    .fault_sense_pin_one_trip  (trip_one),
    .fault_sense_pin_two_trip  (trip_two),
    .sense_one_comparator_off  (off_one),
    .sense_two_comparator_off  (off_two),
    .sense_one_threshold       (thr_one),
    .sense_two_threshold       (thr_two),
    .interrupt_request_out_n   (irq_n),
    .sd_processing_core_format (fmt),
    .route_ch_a                (ch_a),
    .route_ch_b                (ch_b),
    .route_ch_c                (ch_c),
    .analog_input_channel_pd   (pd)
  );

  two_wire_host host (
    .sys_clk  (sys_clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_pull (sda_pull)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    host.write_reg(sub, d, ok);
    chk("write ack", 8'(ok), 8'h01);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] sub, input logic [7:0] exp);
    host.read_reg(sub, rd, ok);
    chk("read ack", 8'(ok), 8'h01);
    chk(what, rd, exp);
  endtask : rdc

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    conclude();
  end

  initial
  begin
    nrst      = 1'b0;
    trip_one  = 1'b0;
    trip_two  = 1'b0;
    err_count = 0;
    tests_run = 0;
    tick(19);
    chk("off one", 8'(off_one), 8'h01);
    chk("off two", 8'(off_two), 8'h01);
    chk("level one", 8'(thr_one), 8'h03);
    chk("level two", 8'(thr_two), 8'h03);
    tick(1);
    nrst = 1'b1;
    tick(4);
    chk("format", 8'(fmt), 8'(FMT_CVBS));
    foreach (ROWS[i])
    begin
      wr(8'h00, {3'h7, ROWS[i].code});
      tick(4);
      pd_exp = 8'hFF;
      if (ROWS[i].a != 4'h0) pd_exp[ROWS[i].a - 4'h1] = 1'b0;
      if (ROWS[i].b != 4'h0) pd_exp[ROWS[i].b - 4'h1] = 1'b0;
      if (ROWS[i].c != 4'h0) pd_exp[ROWS[i].c - 4'h1] = 1'b0;
      chk("format", 8'(fmt), 8'(ROWS[i].fmt));
      chk("ch a", 8'(ch_a), 8'(ROWS[i].a));
      chk("ch b", 8'(ch_b), 8'(ROWS[i].b));
      chk("ch c", 8'(ch_c), 8'(ROWS[i].c));
      chk("power down", pd, pd_exp);
      rdc("route", 8'h00, {3'h0, ROWS[i].code});
    end
    // Sensing is still off, so this trip must leave no trace.
    trip_one = 1'b1;
    tick(6);
    trip_one = 1'b0;
    chk("irq", 8'(irq_n), 8'h01);
    rdc("status", 8'h5F, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h5D, 8'(k << 2));
      chk("level one", 8'(thr_one), 8'(k));
      chk("off one", 8'(off_one), 8'h00);
    end
    wr(8'h5E, 8'h0C);
    chk("level two", 8'(thr_two), 8'h03);
    chk("off two", 8'(off_two), 8'h00);
    rdc("sense two", 8'h5E, 8'h0C);
    trip_one = 1'b1;
    tick(2);
    chk("irq early", 8'(irq_n), 8'h01);
    tick(2);
    chk("irq", 8'(irq_n), 8'h00);
    trip_one = 1'b0;
    tick(4);
    rdc("status", 8'h5F, 8'h01);
    trip_two = 1'b1;
    tick(4);
    trip_two = 1'b0;
    rdc("status", 8'h5F, 8'h03);
    wr(8'h5F, 8'h01);
    rdc("status", 8'h5F, 8'h02);
    chk("irq", 8'(irq_n), 8'h00);
    wr(8'h5F, 8'h02);
    rdc("status", 8'h5F, 8'h00);
    chk("irq", 8'(irq_n), 8'h01);
    trip_two = 1'b1;
    tick(4);
    trip_two = 1'b0;
    chk("irq", 8'(irq_n), 8'h00);
    wr(8'h5E, 8'h4C);
    chk("off two", 8'(off_two), 8'h01);
    chk("irq masked", 8'(irq_n), 8'h01);
    host.start();
    host.xfer({7'h21, 1'b0}, 1'b1, rd, ok);
    host.stop();
    chk("foreign ack", 8'(ok), 8'h00);
    rdc("unmapped", 8'h10, 8'h00);
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick(4);
    chk("off one", 8'(off_one), 8'h01);
    rdc("status", 8'h5F, 8'h00);
    rdc("route", 8'h00, 8'h00);
    conclude();
  end
endmodule : video_input_route_and_fault_sense_tb
`default_nettype wire
